// ==== rtl/mft_pkg.sv ====
// Constants for the multi-function timer, watchdog, RTC and HALT control block.
// Assumes a single 200 MHz clock; slow oscillators arrive as pins and are sampled.
package mft_pkg;
    // Register map
    localparam logic [7:0] ADDR_RTC_RATE    = 8'h09;
    localparam logic [7:0] ADDR_IRQ_CTRL    = 8'h1e;
    localparam logic [7:0] ADDR_STATUS      = 8'h20;
    localparam logic [7:0] ADDR_MASTER_IRQ  = 8'h21;
    localparam logic [7:0] ADDR_OPTIONS     = 8'h22;
    localparam logic [7:0] ADDR_WAKE_ENABLE = 8'h23;
    // Reset values
    localparam logic [7:0] RTC_RATE_RESET   = 8'h07;
    localparam logic [7:0] OPTIONS_RESET    = 8'h00;
    // Field positions
    localparam int RTC_SEL_LSB   = 0;
    localparam int IRQ_EN_TB     = 0;
    localparam int IRQ_EN_RTC    = 1;
    localparam int IRQ_FLAG_TB   = 4;
    localparam int IRQ_FLAG_RTC  = 5;
    localparam int STAT_TIMEOUT  = 5;
    localparam int STAT_PWRDOWN  = 4;
    localparam int STAT_HALTED   = 0;
    localparam int STAT_DUMMY    = 1;
    localparam int OPT_WDT_DIS   = 0;
    localparam int OPT_WDT_DBL   = 1;
    localparam int OPT_SRC_LSB   = 2;
    localparam int OPT_TB_LSB    = 4;
    localparam int OPT_LCD_LSB   = 0;
    // Chain shape
    localparam int DIV_STAGES    = 8;
    localparam int PRE_BITS      = 7;
    localparam int CHAIN_BITS    = DIV_STAGES + PRE_BITS + 1;
    localparam int WDT_MIN_EXP   = 15;
    localparam int LCD_MIN_EXP   = 2;
    localparam int TB_MIN_EXP    = 12;
    localparam int RTC_MIN_EXP   = 8;
    // Wake dummy period in system clocks
    localparam int WAKE_DELAY_CYC = 1024;
    // Vectors
    localparam logic [7:0] VEC_TIMEBASE = 8'h10;
    localparam logic [7:0] VEC_RTC      = 8'h14;
    // Clock source encodings
    localparam logic [1:0] SRC_WDT_OSC = 2'h0;
    localparam logic [1:0] SRC_RTC_OSC = 2'h1;
    localparam logic [1:0] SRC_INSTR   = 2'h2;
    // Instruction clock divide from system clock
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// ==== rtl/mft_watchdog_rtc_halt.sv ====
// Multi-function timer with watchdog, time base, RTC, taps and HALT control.
// Assumes the core pulses its instruction strobes for one clk cycle each and
// runs clk at the system oscillator rate; gating of that oscillator lies outside.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module mft_watchdog_rtc_halt #(
    parameter int WAKE_CYCLES = mft_pkg::WAKE_DELAY_CYC,  // Dummy period length
    parameter int PORT_BITS   = 8                         // Port A width
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 external_reset_pin_n,
    input  wire logic                 wdt_osc_pin,
    input  wire logic                 rtc_osc_pin,
    input  wire logic [PORT_BITS-1:0] port_a,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 halt_instr,
    input  wire logic                 watchdog_clear_instr,
    input  wire logic                 watchdog_clear_first,
    input  wire logic                 watchdog_clear_second,
    input  wire logic                 stack_full,
    input  wire logic                 other_irq_wake,
    input  wire logic                 irq_ack,
    output logic                      irq_request,
    output logic      [7:0]           irq_vector,
    output logic                      chip_reset,
    output logic                      warm_reset,
    output logic                      halted,
    output logic                      sys_osc_stop,
    output logic                      cpu_resume,
    output logic                      lcd_clock,
    output logic                      buzzer_clock,
    output logic                      rtc_timeout_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three flops, change counts when stages two and three agree

    logic [2:0]           sync_res;        // Reset pin chain
    logic [2:0]           sync_wdt;        // Watchdog RC oscillator chain
    logic [2:0]           sync_rtc;        // 32768 Hz oscillator chain
    logic [PORT_BITS-1:0] pa_s1;           // Port A first stage
    logic [PORT_BITS-1:0] pa_s2;           // Port A second stage
    logic [PORT_BITS-1:0] pa_s3;           // Port A third stage
    logic                 res_level;       // Filtered reset pin (low = reset)
    logic                 wdt_level;       // Filtered watchdog oscillator
    logic                 rtc_level;       // Filtered RTC oscillator
    logic [PORT_BITS-1:0] pa_level;        // Filtered port A

    // Each chain shifts on every clock; first flop only feeds the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_res <= 3'h7;
            sync_wdt <= 3'h0;
            sync_rtc <= 3'h0;
            pa_s1    <= '1;
            pa_s2    <= '1;
            pa_s3    <= '1;
        end else begin
            sync_res <= {sync_res[1:0], external_reset_pin_n};
            sync_wdt <= {sync_wdt[1:0], wdt_osc_pin};
            sync_rtc <= {sync_rtc[1:0], rtc_osc_pin};
            pa_s1    <= port_a;
            pa_s2    <= pa_s1;
            pa_s3    <= pa_s2;
        end
    end

    // Filtered levels only move when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_level <= 1'b1;
            wdt_level <= 1'b0;
            rtc_level <= 1'b0;
            pa_level  <= '1;
        end else begin
            if (sync_res[1] == sync_res[2]) begin
                res_level <= sync_res[2];
            end
            if (sync_wdt[1] == sync_wdt[2]) begin
                wdt_level <= sync_wdt[2];
            end
            if (sync_rtc[1] == sync_rtc[2]) begin
                rtc_level <= sync_rtc[2];
            end
            for (int i = 0; i < PORT_BITS; i++) begin
                if (pa_s2[i] == pa_s3[i]) begin
                    pa_level[i] <= pa_s3[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]           rtc_rate_control;  // Rate select in low bits
    logic [7:0]           options;           // Mask option emulation
    logic [7:0]           lcd_buz_sel;       // LCD tap low nibble, buzzer high
    logic [PORT_BITS-1:0] wake_enable;       // Per-pin wake enables
    logic                 en_tb;             // Time base interrupt enable
    logic                 en_rtc;            // RTC interrupt enable
    logic                 timebase_flag;     // Time base request
    logic                 rtc_flag;          // RTC request
    logic                 master_irq_enable; // Global interrupt enable
    logic                 timeout_flag;      // Watchdog overflow seen
    logic                 powerdown_flag;    // HALT executed
    logic                 wdt_disabled;      // Watchdog off by option
    logic                 wdt_double;        // Two-instruction clear option
    logic [1:0]           src_sel;           // Chain clock source
    logic [1:0]           tb_sel;            // Time base period select
    logic [2:0]           rtc_sel;           // RTC divide select
    logic                 dummy_active;      // Wake delay running

    assign wdt_disabled = options[mft_pkg::OPT_WDT_DIS];
    assign wdt_double   = options[mft_pkg::OPT_WDT_DBL];
    assign src_sel      = options[mft_pkg::OPT_SRC_LSB +: 2];
    assign tb_sel       = options[mft_pkg::OPT_TB_LSB +: 2];
    assign rtc_sel      = rtc_rate_control[mft_pkg::RTC_SEL_LSB +: 3];

    // Writable configuration; rate select reset 111 keeps the slowest period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rtc_rate_control <= mft_pkg::RTC_RATE_RESET;
            options          <= mft_pkg::OPTIONS_RESET;
            lcd_buz_sel      <= 8'h00;
            wake_enable      <= '0;
            en_tb            <= 1'b0;
            en_rtc           <= 1'b0;
        end else if (reg_write) begin
            case (reg_addr)
                mft_pkg::ADDR_RTC_RATE:    rtc_rate_control <= reg_wdata;
                mft_pkg::ADDR_OPTIONS:     options          <= reg_wdata;
                mft_pkg::ADDR_STATUS:      lcd_buz_sel      <= reg_wdata;
                mft_pkg::ADDR_WAKE_ENABLE: wake_enable      <= reg_wdata[PORT_BITS-1:0];
                mft_pkg::ADDR_IRQ_CTRL: begin
                    en_tb  <= reg_wdata[mft_pkg::IRQ_EN_TB];
                    en_rtc <= reg_wdata[mft_pkg::IRQ_EN_RTC];
                end
                default: ;
            endcase
        end
    end

    // Read data appear the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                mft_pkg::ADDR_RTC_RATE:    reg_rdata <= rtc_rate_control;
                mft_pkg::ADDR_OPTIONS:     reg_rdata <= options;
                mft_pkg::ADDR_WAKE_ENABLE: reg_rdata <= 8'(wake_enable);
                mft_pkg::ADDR_MASTER_IRQ:  reg_rdata <= {7'h00, master_irq_enable};
                mft_pkg::ADDR_IRQ_CTRL:    reg_rdata <= {2'h0, rtc_flag, timebase_flag,
                                                         2'h0, en_rtc, en_tb};
                mft_pkg::ADDR_STATUS:      reg_rdata <= {2'h0, timeout_flag, powerdown_flag,
                                                         2'h0, dummy_active, halted};
                default:                   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and divider/prescaler chain

    logic       wdt_prev;                         // Edge detect of osc level
    logic       rtc_prev;
    logic [1:0] instr_div;                        // System clock / 4
    logic       src_tick;                         // One chain advance
    logic [mft_pkg::CHAIN_BITS-1:0] chain;        // Divider + prescaler + carry
    logic [mft_pkg::CHAIN_BITS-1:0] next_chain;
    logic [mft_pkg::CHAIN_BITS-1:0] rise;         // Stage outputs rising this cycle
    logic       wdt_clear;                        // Watchdog clear request

    // Edge detectors read the filtered level, never the first sync flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_prev  <= 1'b0;
            rtc_prev  <= 1'b0;
            instr_div <= 2'h0;
        end else begin
            wdt_prev  <= wdt_level;
            rtc_prev  <= rtc_level;
            instr_div <= instr_div + 2'h1;
        end
    end

    // Instruction clock ceases in HALT because the system oscillator is stopped
    always_comb begin
        case (src_sel)
            mft_pkg::SRC_WDT_OSC: src_tick = wdt_level & ~wdt_prev;
            mft_pkg::SRC_RTC_OSC: src_tick = rtc_level & ~rtc_prev;
            mft_pkg::SRC_INSTR:   src_tick = ~halted && (instr_div == mft_pkg::INSTR_DIV_LAST);
            default:              src_tick = 1'b0;
        endcase
    end

    assign next_chain = chain + {{(mft_pkg::CHAIN_BITS-1){1'b0}}, src_tick};
    assign rise       = next_chain & ~chain;

    // One binary counter: low 8 bits the divider, next 7 the prescaler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frequency taps

    // Tap n toggles at src/2^n, so output n gives src/2^(n+1) square wave
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lcd_clock    <= 1'b0;
            buzzer_clock <= 1'b0;
        end else begin
            // LCD /2^2..2^8; out-of-range select saturates at slowest
            lcd_clock    <= chain[mft_pkg::LCD_MIN_EXP - 1 +
                                  ((lcd_buz_sel[3:0] > 4'h6) ? 6 : int'(lcd_buz_sel[3:0]))];
            buzzer_clock <= chain[mft_pkg::LCD_MIN_EXP - 1 +
                                  ((lcd_buz_sel[7:4] > 4'h7) ? 7 : int'(lcd_buz_sel[7:4]))];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base and RTC

    logic tb_tick;   // Time base timeout
    logic flags_at_halt_tb;   // Flag was set when HALT began
    logic flags_at_halt_rtc;
    logic vec_tb;    // Time base call taken
    logic vec_rtc;   // RTC call taken

    // Bit k rises once per 2^(k+1) ticks, so a /2^n period takes bit n-1
    assign tb_tick          = rise[mft_pkg::TB_MIN_EXP - 1 + int'(tb_sel)];
    assign rtc_timeout_tick = rise[mft_pkg::RTC_MIN_EXP - 1 + int'(rtc_sel)];

    // Time base wins priority over RTC at the same point
    always_comb begin
        vec_tb  = irq_ack && master_irq_enable && en_tb && timebase_flag && !stack_full;
        vec_rtc = irq_ack && master_irq_enable && en_rtc && rtc_flag && !stack_full
                  && !vec_tb;
    end

    // Flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timebase_flag <= 1'b0;
            rtc_flag      <= 1'b0;
        end else begin
            if (tb_tick) begin
                timebase_flag <= 1'b1;
            end else if (vec_tb || (reg_write && reg_addr == mft_pkg::ADDR_IRQ_CTRL)) begin
                timebase_flag <= vec_tb ? 1'b0 : reg_wdata[mft_pkg::IRQ_FLAG_TB];
            end
            if (rtc_timeout_tick) begin
                rtc_flag <= 1'b1;
            end else if (vec_rtc || (reg_write && reg_addr == mft_pkg::ADDR_IRQ_CTRL)) begin
                rtc_flag <= vec_rtc ? 1'b0 : reg_wdata[mft_pkg::IRQ_FLAG_RTC];
            end
        end
    end

    // Master enable: cleared on vectoring, software writes otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_irq_enable <= 1'b0;
        end else if (vec_tb || vec_rtc) begin
            master_irq_enable <= 1'b0;
        end else if (reg_write && reg_addr == mft_pkg::ADDR_MASTER_IRQ) begin
            master_irq_enable <= reg_wdata[0];
        end
    end

    // Request to core; held off during HALT and the dummy period
    always_comb begin
        irq_request = 1'b0;
        irq_vector  = 8'h00;
        if (!halted && !dummy_active && master_irq_enable && !stack_full) begin
            if (en_tb && timebase_flag) begin
                irq_request = 1'b1;
                irq_vector  = mft_pkg::VEC_TIMEBASE;
            end else if (en_rtc && rtc_flag) begin
                irq_request = 1'b1;
                irq_vector  = mft_pkg::VEC_RTC;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog

    logic clear_first_seen;   // First half of double clear
    logic clear_second_seen;  // Second half of double clear
    logic wdt_overflow;       // Count at 2^15-1 on a source tick; bit 15 never sets
    logic [mft_pkg::WDT_MIN_EXP:0] wdt_count;  // Own count beside the chain

    // Single mode takes one instruction, double mode needs both halves
    always_comb begin
        if (wdt_double) begin
            wdt_clear = (clear_first_seen || watchdog_clear_first)
                      && (clear_second_seen || watchdog_clear_second);
        end else begin
            wdt_clear = watchdog_clear_instr;
        end
    end

    // Track the halves of a double clear until both are done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clear_first_seen  <= 1'b0;
            clear_second_seen <= 1'b0;
        end else if (wdt_clear || !wdt_double || wdt_disabled) begin
            clear_first_seen  <= 1'b0;
            clear_second_seen <= 1'b0;
        end else begin
            clear_first_seen  <= clear_first_seen  | watchdog_clear_first;
            clear_second_seen <= clear_second_seen | watchdog_clear_second;
        end
    end

    // Overflow on the tick that would take the count to 2^15, i.e. 2^15 source ticks after the last clear
    assign wdt_overflow = !wdt_disabled && src_tick
                        && (wdt_count == {1'b0, {mft_pkg::WDT_MIN_EXP{1'b1}}});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_count <= '0;
        end else if (wdt_disabled) begin
            wdt_count <= '0;
        end else if (!res_level || wdt_clear || wdt_overflow
                     || (halt_instr && src_sel != mft_pkg::SRC_INSTR)) begin
            wdt_count <= '0;
        end else if (src_tick) begin
            wdt_count <= wdt_count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // HALT, wake and reset outputs

    logic [$clog2(WAKE_CYCLES+1)-1:0] dummy_count;  // Wake delay counter
    logic                             port_wake;    // Enabled port A falling edge
    logic [PORT_BITS-1:0]             pa_prev;      // Last filtered port level
    logic                             irq_wake;     // New interrupt while halted

    assign port_wake = |(pa_prev & ~pa_level & wake_enable);
    assign irq_wake  = (timebase_flag && !flags_at_halt_tb)
                     || (rtc_flag && !flags_at_halt_rtc) || other_irq_wake;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pa_prev <= '1;
        end else begin
            pa_prev <= pa_level;
        end
    end

    // HALT entry snapshots flags; any wake source starts the dummy period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted            <= 1'b0;
            flags_at_halt_tb  <= 1'b0;
            flags_at_halt_rtc <= 1'b0;
            dummy_active      <= 1'b0;
            dummy_count       <= '0;
        end else if (!res_level) begin
            halted       <= 1'b0;
            dummy_active <= 1'b0;
        end else if (halt_instr && !halted) begin
            halted            <= 1'b1;
            flags_at_halt_tb  <= timebase_flag;
            flags_at_halt_rtc <= rtc_flag;
        end else if (halted && (port_wake || irq_wake || wdt_overflow)) begin
            halted       <= 1'b0;
            dummy_active <= 1'b1;
            dummy_count  <= '0;
        end else if (dummy_active) begin
            if (dummy_count == ($bits(dummy_count))'(WAKE_CYCLES - 1)) begin
                dummy_active <= 1'b0;
            end
            dummy_count <= dummy_count + 1'b1;
        end
    end

    // Status flags: power-up clears both; reset pin leaves them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
        end else begin
            if (wdt_overflow) begin
                timeout_flag <= 1'b1;
            end else if (halt_instr && !wdt_disabled) begin
                timeout_flag <= 1'b0;
            end
            if (halt_instr && !wdt_disabled) begin
                powerdown_flag <= 1'b1;
            end else if (wdt_clear && !wdt_disabled) begin
                powerdown_flag <= 1'b0;
            end
        end
    end

    // Reset pulses to the core; resume pulses when dummy period ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_reset <= 1'b0;
            warm_reset <= 1'b0;
            cpu_resume <= 1'b0;
        end else begin
            chip_reset <= !res_level || (wdt_overflow && !halted);
            warm_reset <= wdt_overflow && halted;
            // Core then takes the call if enabled, else next instruction
            cpu_resume <= dummy_active
                       && dummy_count == ($bits(dummy_count))'(WAKE_CYCLES - 1);
        end
    end

    // System oscillator stops for the whole HALT; slow oscillators are pins and keep running
    assign sys_osc_stop = halted;

endmodule

// ==== test/mft_core_model.sv ====
// Behavioural core: takes each offered interrupt call.
// Assumes irq_request holds until the call is acknowledged.
`timescale 1ns/1ps
module mft_core_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic irq_request,
    output logic      irq_ack
);
    // Ack on the cycle after the request, like a core finishing its fetch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= irq_request && !irq_ack;
        end
    end
endmodule

// ==== test/mft_watchdog_rtc_halt_sva.sv ====
// Port checker for the timer block.
// Assumes one clk domain with async rst.
`timescale 1ns/1ps
module mft_watchdog_rtc_halt_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       external_reset_pin_n,
    input wire logic       halt_instr,
    input wire logic       irq_ack,
    input wire logic       irq_request,
    input wire logic       chip_reset,
    input wire logic       warm_reset,
    input wire logic       halted,
    input wire logic       cpu_resume,
    input wire logic       rtc_timeout_tick,
    input wire logic [7:0] irq_vector
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Raw pin held low long enough to pass the filter
    sequence pin_low;
        !external_reset_pin_n [*6];
    endsequence
    AST_VECTOR: assert property (irq_request |-> irq_vector inside {8'h10, 8'h14})
        else $error("bad vector");
    AST_ACK_CLEARS: assert property (irq_ack && irq_request |=> !irq_request)
        else $error("request stays after ack");
    AST_WARM_IN_HALT: assert property ($rose(warm_reset) |-> $past(halted))
        else $error("warm reset outside halt");
    AST_WARM_PULSE: assert property (warm_reset |=> !warm_reset)
        else $error("warm reset too long");
    AST_HALT_CAUSE: assert property ($rose(halted) |-> $past(halt_instr))
        else $error("halt without instruction");
    AST_RESUME_PULSE: assert property (cpu_resume |=> !cpu_resume)
        else $error("resume too long");
    AST_TICK_PULSE: assert property (rtc_timeout_tick |=> !rtc_timeout_tick)
        else $error("rtc tick too long");
    AST_PIN_RESET: assert property (pin_low |-> chip_reset)
        else $error("pin low without reset");
endmodule
bind mft_watchdog_rtc_halt mft_watchdog_rtc_halt_sva chk (.clk, .rst, .external_reset_pin_n,
    .halt_instr, .irq_ack, .irq_request, .chip_reset, .warm_reset, .halted, .cpu_resume,
    .rtc_timeout_tick, .irq_vector);

// ==== test/testbench.sv ====
// Register-level bench for the timer block.
// Assumes clk/4 chain source; short wake delay of 16 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic clk = 0, rst = 1, pin_n = 1, wr_s = 0, rd_s = 0, ack, req;
    logic [7:0] addr = 0, wd = 0, rdv, pa = 8'hff, d;
    logic [3:0] ins = 0;   // halt, clear, clear first, clear second
    int failures = 0, n_checks = 0, n;
    logic crst, hlt, sosc, lck, bck;   // Reset, halt, osc stop, LCD and buzzer taps
    logic [7:0] vec;                   // Offered vector
    time t0;                           // Start of a tap period
    initial forever #2.5 clk = ~clk;
    mft_watchdog_rtc_halt #(.WAKE_CYCLES(16)) uut (.clk, .rst, .external_reset_pin_n(pin_n),
        .wdt_osc_pin(1'b0), .rtc_osc_pin(1'b0), .port_a(pa), .reg_addr(addr), .reg_wdata(wd),
        .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdv), .halt_instr(ins[0]),
        .watchdog_clear_instr(ins[1]), .watchdog_clear_first(ins[2]),
        .watchdog_clear_second(ins[3]), .stack_full(1'b0), .other_irq_wake(1'b0),
        .irq_ack(ack), .irq_request(req), .irq_vector(vec), .chip_reset(crst), .warm_reset(),
        .halted(hlt), .sys_osc_stop(sosc), .cpu_resume(), .lcd_clock(lck), .buzzer_clock(bck),
        .rtc_timeout_tick());
    mft_core_model core (.clk, .rst, .irq_request(req), .irq_ack(ack));
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) {addr, wd, wr_s} <= {a, v, 1'b1};
        @(posedge clk) wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk) {addr, rd_s} <= {a, 1'b1};
        @(posedge clk) rd_s <= 1'b0;
        #1 d = rdv;
    endtask
    task inst(input int i);
        @(posedge clk) ins <= 4'h1 << i;
        @(posedge clk) ins <= 4'h0;
    endtask
    // Cycles until the next rtc tick, bounded
    task tick();
        n = 0;
        do begin @(negedge clk); n++; end while (!uut.rtc_timeout_tick && n < 20000);
    endtask
    task give_verdict();
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #350us failures++; give_verdict(); end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h09); `CHK(d, 8'h07)
        rd(8'h00); `CHK(d, 8'h00)
        wr(8'h22, 8'h38);
        // LCD tap /2^8 and buzzer tap /2^3 of clk/4; first edge may be a switch glitch
        wr(8'h20, 8'h16);
        @(posedge lck); @(posedge lck) t0 = $time;
        @(posedge lck) `CHK($time - t0, 64'd5120)
        @(posedge bck) t0 = $time;
        @(posedge bck) `CHK($time - t0, 64'd160)
        for (int c = 0; c < 3; c++) begin
            wr(8'h09, c[7:0]); rd(8'h09); `CHK(d, c[7:0])
            tick(); tick(); `CHK(n, 4 << (8 + c))
        end
        rd(8'h1e); `CHK(d & 8'h20, 8'h20)
        wr(8'h09, 8'h04);
        wr(8'h1e, 8'h02); wr(8'h21, 8'h01); tick();
        @(negedge clk) `CHK(vec, 8'h14)
        repeat (4) @(posedge clk);
        rd(8'h21); `CHK(d[0], 1'b0)
        rd(8'h1e); `CHK(d & 8'h20, 8'h00)
        wr(8'h09, 8'h07); wr(8'h23, 8'h01); inst(0);
        rd(8'h20); `CHK(d & 8'h11, 8'h11)
        `CHK({hlt, sosc}, 2'h3)
        @(posedge clk) pa <= 8'hfe;
        n = 0;
        do begin @(negedge clk); n++; end while (!uut.cpu_resume && n < 100);
        `CHK(n >= 16 && n <= 24, 1'b1)
        rd(8'h20); `CHK(d & 8'h11, 8'h10)
        inst(1); rd(8'h20); `CHK(d & 8'h10, 8'h00)
        wr(8'h22, 8'h3a); inst(0);
        @(posedge clk) pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(crst, 1'b1)
        pin_n <= 1'b1;
        rd(8'h20); `CHK(d & 8'h11, 8'h10)
        inst(1); rd(8'h20); `CHK(d & 8'h10, 8'h10)
        inst(2); rd(8'h20); `CHK(d & 8'h10, 8'h10)
        inst(3); rd(8'h20); `CHK(d & 8'h10, 8'h00)
        give_verdict();
    end
endmodule
